// File: src/isr_pkg.sv
package isr_pkg;
    // standard event bit positions
    localparam int EV_OPC_BIT = 0;
    localparam int EV_QYE_BIT = 2;
    localparam int EV_DDE_BIT = 3;
    localparam int EV_EXE_BIT = 4;
    localparam int EV_CME_BIT = 5;
    localparam int EV_PON_BIT = 7;
    // status byte bit positions
    localparam int SB_QUESTIONABLE_SUMMARY_BIT = 3;
    localparam int SB_MAV_BIT = 4;
    localparam int SB_ESB_BIT = 5;
    localparam int SB_RQS_BIT = 6;
    // implemented bits of each byte
    localparam logic [7:0] EV_USED_MASK = 8'h00_BD;
    localparam logic [7:0] SB_EN_USED_MASK = 8'h00_38;
    // reset values
    localparam logic [7:0] EV_RESET = 8'h00_80;
    localparam logic [7:0] MASK_RESET = 8'h00_00;

    // event sources, one-cycle pulses
    typedef struct packed {
        logic opcDone;
        logic queryErr;
        logic deviceErr;
        logic execErr;
        logic cmdErr;
    } isr_events_t;

    // register commands from the command executor
    typedef struct packed {
        logic clearStatus;
        logic eventRegQuery;
        logic statusByteQuery;
        logic serialPoll;
        logic eventEnableWrite;
        logic serviceEnableWrite;
        logic pscWrite;
        logic pscValue;
        logic [7:0] wrData;
    } isr_cmd_t;
endpackage

// File: src/isr_status.sv
`timescale 1ns/1ps
module isr_status
    import isr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // event sources
    input wire isr_events_t events,
    input wire logic quesSummary,
    input wire logic outBufNotEmpty,
    // register commands, executed in command order
    input wire isr_cmd_t cmd,
    // read data
    output logic [7:0] eventRegData,
    output logic [7:0] statusByteData,
    output logic [7:0] eventEnableData,
    output logic [7:0] serviceEnableData,
    output logic powerOnClearData,
    // error queue and bus
    output logic errPush,
    output logic serviceRequest
);
    logic [7:0] evReg, evNext;
    logic [7:0] evEnReg, evEnNext;
    logic [7:0] srEnReg, srEnNext;
    logic pscReg, pscNext;
    logic rqsReg, rqsNext;
    logic pwrUpReg;
    logic [7:0] evRdReg, evRdNext;
    logic [7:0] sbRdReg, sbRdNext;
    logic [7:0] evEnRdReg, srEnRdReg;
    logic pscRdReg, errPushReg, errPushNext;
    logic esbLive, summaryHit, rqsCause;
    logic [7:0] evSet, sbLive;

    // event sources
    always_comb begin
        evSet = '0;
        evSet[EV_OPC_BIT] = events.opcDone;
        evSet[EV_QYE_BIT] = events.queryErr;
        evSet[EV_DDE_BIT] = events.deviceErr;
        evSet[EV_EXE_BIT] = events.execErr;
        evSet[EV_CME_BIT] = events.cmdErr;
    end

    // summary bits are live, never latched
    assign esbLive = |(evReg & evEnReg);
    always_comb begin
        sbLive = '0;
        sbLive[SB_QUESTIONABLE_SUMMARY_BIT] = quesSummary;
        sbLive[SB_MAV_BIT] = outBufNotEmpty;
        sbLive[SB_ESB_BIT] = esbLive;
    end
    assign summaryHit = |(sbLive & srEnReg & SB_EN_USED_MASK);
    assign rqsCause = |(sbLive & ~(8'h00_01 << SB_ESB_BIT) & srEnReg
        & SB_EN_USED_MASK);

    // event register and request service
    always_comb begin
        evNext = evReg;
        rqsNext = rqsReg;
        errPushNext = |(evSet & 8'h00_3C);
        if (cmd.clearStatus || cmd.eventRegQuery) begin
            evNext = '0;
        end
        evNext = (evNext | evSet) & EV_USED_MASK;
        if (cmd.serialPoll || cmd.clearStatus) begin
            rqsNext = 1'b0;
        end else if (cmd.eventRegQuery && !rqsCause) begin
            rqsNext = 1'b0;
        end
        if (summaryHit && !rqsReg) begin
            rqsNext = 1'b1;
        end
    end

    // enable masks and power-on clear setting
    always_comb begin
        evEnNext = evEnReg;
        srEnNext = srEnReg;
        pscNext = pscReg;
        if (cmd.eventEnableWrite) begin
            evEnNext = cmd.wrData & EV_USED_MASK;
        end
        if (cmd.serviceEnableWrite) begin
            srEnNext = cmd.wrData & SB_EN_USED_MASK;
        end
        if (cmd.pscWrite) begin
            pscNext = cmd.pscValue;
        end
    end

    // read data, captured at the query, in command order
    always_comb begin
        evRdNext = evRdReg;
        sbRdNext = sbRdReg;
        if (cmd.eventRegQuery) begin
            evRdNext = evReg;
        end
        if (cmd.statusByteQuery || cmd.serialPoll) begin
            sbRdNext = sbLive;
            sbRdNext[SB_RQS_BIT] = rqsReg;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            // power-up: event bit 7 set, masks by power-on clear
            evReg <= EV_RESET;
            rqsReg <= 1'b0;
            pwrUpReg <= 1'b1;
            evRdReg <= '0;
            sbRdReg <= '0;
            errPushReg <= 1'b0;
        end else begin
            evReg <= evNext;
            rqsReg <= rqsNext;
            pwrUpReg <= 1'b0;
            evRdReg <= evRdNext;
            sbRdReg <= sbRdNext;
            errPushReg <= errPushNext;
        end
    end

    // masks and setting are nonvolatile; masks cleared once after power-up when the power-on clear setting is set
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pscReg <= pscReg;
            evEnReg <= evEnReg;
            srEnReg <= srEnReg;
        end else if (pwrUpReg && pscReg) begin
            pscReg <= pscNext;
            evEnReg <= MASK_RESET;
            srEnReg <= MASK_RESET;
        end else begin
            pscReg <= pscNext;
            evEnReg <= evEnNext;
            srEnReg <= srEnNext;
        end
    end

    always_ff @(posedge clk) begin
        evEnRdReg <= evEnReg;
        srEnRdReg <= srEnReg;
        pscRdReg <= pscReg;
    end

    assign eventRegData = evRdReg;
    assign statusByteData = sbRdReg;
    assign eventEnableData = evEnRdReg;
    assign serviceEnableData = srEnRdReg;
    assign powerOnClearData = pscRdReg;
    assign errPush = errPushReg;
    assign serviceRequest = rqsReg;

    // assertions
    a_ev_latch: assert property (@(posedge clk) disable iff (!nrst)
        evReg[EV_EXE_BIT] && !cmd.clearStatus && !cmd.eventRegQuery
        |=> evReg[EV_EXE_BIT])
        else $error("event bit lost");
    a_ev_set: assert property (@(posedge clk) disable iff (!nrst)
        events.cmdErr |=> evReg[EV_CME_BIT])
        else $error("command error not latched");
    a_ev_opc: assert property (@(posedge clk) disable iff (!nrst)
        events.opcDone |=> evReg[EV_OPC_BIT])
        else $error("opc not latched");
    a_ev_clear: assert property (@(posedge clk) disable iff (!nrst)
        cmd.clearStatus && evSet == 8'h00_00 |=> evReg == 8'h00_00)
        else $error("clear status failed");
    a_ev_zero: assert property (@(posedge clk) disable iff (!nrst)
        evReg[1] == 1'b0 && evReg[6] == 1'b0)
        else $error("unused event bits set");
    a_err_push: assert property (@(posedge clk) disable iff (!nrst)
        events.queryErr || events.deviceErr |=> errPush)
        else $error("error queue not pushed");
    a_poll_clear: assert property (@(posedge clk) disable iff (!nrst)
        cmd.serialPoll && !summaryHit |=> !serviceRequest)
        else $error("poll left request set");
    a_stb_keep: assert property (@(posedge clk) disable iff (!nrst)
        cmd.statusByteQuery && rqsReg && !cmd.serialPoll
        && !cmd.clearStatus && !cmd.eventRegQuery |=> rqsReg)
        else $error("status query cleared request");
    a_rqs_set: assert property (@(posedge clk) disable iff (!nrst)
        summaryHit && !cmd.serialPoll && !cmd.clearStatus
        && !cmd.eventRegQuery |=> serviceRequest)
        else $error("request not raised");
    a_poll_data: assert property (@(posedge clk) disable iff (!nrst)
        cmd.serialPoll |=> statusByteData[SB_MAV_BIT]
        == $past(outBufNotEmpty))
        else $error("poll data wrong");
    a_mask_keep: assert property (@(posedge clk) disable iff (!nrst)
        cmd.clearStatus && !cmd.eventEnableWrite && !pwrUpReg
        |=> $stable(evEnReg))
        else $error("clear status touched mask");

    // remaining event sources
    a_qye_set: assert property (@(posedge clk) disable iff (!nrst)
        events.queryErr |=> evReg[EV_QYE_BIT])
        else $error("query error not latched");

    a_dde_set: assert property (@(posedge clk) disable iff (!nrst)
        events.deviceErr |=> evReg[EV_DDE_BIT])
        else $error("device error not latched");

    a_exe_set: assert property (@(posedge clk) disable iff (!nrst)
        events.execErr |=> evReg[EV_EXE_BIT])
        else $error("execution error not latched");

    a_err_late: assert property (@(posedge clk) disable iff (!nrst)
        events.execErr || events.cmdErr |=> errPush)
        else $error("error queue not pushed");

    // event query clears and captures
    a_esr_clear: assert property (@(posedge clk) disable iff (!nrst)
        cmd.eventRegQuery && evSet == 8'h00_00
        |=> evReg == 8'h00_00)
        else $error("event query left bits set");

    a_esr_capture: assert property (@(posedge clk) disable iff (!nrst)
        cmd.eventRegQuery
        |=> eventRegData == $past(evReg))
        else $error("event query data wrong");

    // status byte contents
    a_esb_high: assert property (@(posedge clk) disable iff (!nrst)
        cmd.statusByteQuery && |(evReg & evEnReg)
        |=> statusByteData[SB_ESB_BIT])
        else $error("event summary missing");

    a_esb_low: assert property (@(posedge clk) disable iff (!nrst)
        cmd.statusByteQuery && !(|(evReg & evEnReg))
        |=> !statusByteData[SB_ESB_BIT])
        else $error("event summary stale");

    a_questionable_summary_data: assert property (@(posedge clk) disable iff (!nrst)
        cmd.statusByteQuery
        |=> statusByteData[SB_QUESTIONABLE_SUMMARY_BIT] == $past(quesSummary))
        else $error("questionable summary wrong");

    a_mav_data: assert property (@(posedge clk) disable iff (!nrst)
        cmd.statusByteQuery
        |=> statusByteData[SB_MAV_BIT] == $past(outBufNotEmpty))
        else $error("message available wrong");

    a_sb_unused: assert property (@(posedge clk) disable iff (!nrst)
        statusByteData[7] == 1'b0
        && statusByteData[2:0] == 3'h0)
        else $error("unused status bits set");

    // request service clearing
    a_cls_rqs: assert property (@(posedge clk) disable iff (!nrst)
        cmd.clearStatus && !summaryHit
        |=> !serviceRequest)
        else $error("clear status left request");

    a_esr_rqs: assert property (@(posedge clk) disable iff (!nrst)
        cmd.eventRegQuery && rqsReg && !rqsCause
        |=> !serviceRequest)
        else $error("event query left request");

    a_esr_keep: assert property (@(posedge clk) disable iff (!nrst)
        cmd.eventRegQuery && rqsReg && rqsCause && !cmd.serialPoll
        && !cmd.clearStatus |=> serviceRequest)
        else $error("event query cleared other request");

    // polls and status queries leave events alone
    a_poll_ev: assert property (@(posedge clk) disable iff (!nrst)
        cmd.serialPoll && !cmd.clearStatus && !cmd.eventRegQuery
        && evSet == 8'h00_00 |=> $stable(evReg))
        else $error("poll changed events");

    a_stb_ev: assert property (@(posedge clk) disable iff (!nrst)
        cmd.statusByteQuery && !cmd.clearStatus && !cmd.eventRegQuery
        && evSet == 8'h00_00 |=> $stable(evReg))
        else $error("status query changed events");

    // masks: zero write and power-on clear
    a_ev_mask_zero: assert property (@(posedge clk) disable iff (!nrst)
        cmd.eventEnableWrite && cmd.wrData == 8'h00_00
        |=> evEnReg == 8'h00_00)
        else $error("event mask not cleared");

    a_sv_mask_zero: assert property (@(posedge clk) disable iff (!nrst)
        cmd.serviceEnableWrite && cmd.wrData == 8'h00_00
        |=> srEnReg == 8'h00_00)
        else $error("service mask not cleared");

    a_psc_clear: assert property (@(posedge clk) disable iff (!nrst)
        pwrUpReg && pscReg
        |=> evEnReg == 8'h00_00 && srEnReg == 8'h00_00)
        else $error("power-on clear missed");

    c_poll: cover property (@(posedge clk) disable iff (!nrst)
        serviceRequest ##1 cmd.serialPoll);
    c_psc: cover property (@(posedge clk) disable iff (!nrst)
        pwrUpReg && pscReg);
    c_rerise: cover property (@(posedge clk) disable iff (!nrst)
        cmd.serialPoll ##1 !serviceRequest ##1 serviceRequest);
    c_esr: cover property (@(posedge clk) disable iff (!nrst)
        esbLive ##1 cmd.eventRegQuery);
    c_cls: cover property (@(posedge clk) disable iff (!nrst)
        cmd.clearStatus && evReg != 8'h00_00);
endmodule

// File: sim/isr_ctrl_model.sv
`timescale 1ns/1ps
module isr_ctrl_model
    import isr_pkg::*;
(
    // clock
    input wire logic clk,
    // command stream toward the block
    output isr_cmd_t cmd
);
    initial begin
        cmd = '0;
    end
    // one command per call, taken at one edge, answer settled on return
    task automatic send(input isr_cmd_t c);
        @(posedge clk);
        #1 cmd = c;
        @(posedge clk);
        #1 cmd = '0;
        @(posedge clk);
        #1;
    endtask
endmodule

// File: sim/instrument_status_reporting_tb.sv
`timescale 1ns/1ps
module instrument_status_reporting_tb
    import isr_pkg::*;
;
    typedef struct {
        isr_events_t ev;
        logic push;
        logic [7:0] val;
    } isr_row_t;
    logic clk, nrst, quesSummary, outBufNotEmpty, errPush, serviceRequest;
    logic powerOnClearData, evPush;
    isr_events_t events;
    isr_cmd_t cmd;
    logic [7:0] eventRegData, statusByteData;
    logic [7:0] eventEnableData, serviceEnableData;
    int n_errors, compares;
    isr_row_t rows[5] = '{'{5'h10, 1'b0, 8'h01}, '{5'h08, 1'b1, 8'h04},
        '{5'h04, 1'b1, 8'h08}, '{5'h02, 1'b1, 8'h10}, '{5'h01, 1'b1, 8'h20}};

    isr_ctrl_model ctl (.clk(clk), .cmd(cmd));
    isr_status uut (.clk(clk), .nrst(nrst), .events(events),
        .quesSummary(quesSummary), .outBufNotEmpty(outBufNotEmpty),
        .cmd(cmd), .eventRegData(eventRegData),
        .statusByteData(statusByteData), .eventEnableData(eventEnableData),
        .serviceEnableData(serviceEnableData),
        .powerOnClearData(powerOnClearData), .errPush(errPush),
        .serviceRequest(serviceRequest));

    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic ev(input isr_events_t e);
        @(posedge clk);
        #1 events = e;
        @(posedge clk);
        #1 events = '0;
        evPush = errPush;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic sbq(input logic [7:0] e);
        ctl.send(16'h2000);
        chk("status byte", e, statusByteData);
    endtask
    task automatic erq(input logic [7:0] e);
        ctl.send(16'h4000);
        chk("event reg", e, eventRegData);
    endtask
    task automatic close_out;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial begin
        nrst = 0;
        events = '0;
        quesSummary = 0;
        outBufNotEmpty = 0;
        n_errors = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        #1 nrst = 1;
        ctl.send(16'h0200);
        chk("psc", 8'h00, {7'h0, powerOnClearData});
        ctl.send(16'h08ff);
        ctl.send(16'h0420);
        chk("ev mask", 8'hbd, eventEnableData);
        chk("sv mask", 8'h20, serviceEnableData);
        repeat (2) @(posedge clk);
        #1 chk("srq", 8'h01, {7'h0, serviceRequest});
        erq(8'h80);
        chk("srq", 8'h00, {7'h0, serviceRequest});
        $display("test power on done");
        foreach (rows[i]) begin
            ev(rows[i].ev);
            chk("push", {7'h0, rows[i].push}, {7'h0, evPush});
            erq(rows[i].val);
        end
        $display("test event rows done");
        ctl.send(16'h0438);
        outBufNotEmpty = 1;
        sbq(8'h50);
        sbq(8'h50);
        ctl.send(16'h1000);
        chk("poll", 8'h50, statusByteData);
        outBufNotEmpty = 0;
        quesSummary = 1;
        sbq(8'h48);
        quesSummary = 0;
        ctl.send(16'h1000);
        chk("poll", 8'h40, statusByteData);
        sbq(8'h00);
        $display("test summary done");
        ev(5'h01);
        sbq(8'h60);
        ctl.send(16'h8000);
        sbq(8'h00);
        erq(8'h00);
        chk("ev mask", 8'hbd, eventEnableData);
        quesSummary = 1;
        ev(5'h01);
        erq(8'h20);
        sbq(8'h48);
        quesSummary = 0;
        ctl.send(16'h8000);
        ctl.send(16'h0800);
        ev(5'h01);
        sbq(8'h00);
        $display("test clear done");
        ctl.send(16'h0300);
        ctl.send(16'h08ff);
        ctl.send(16'h0420);
        nrst = 0;
        repeat (3) @(posedge clk);
        #1 nrst = 1;
        repeat (3) @(posedge clk);
        #1 chk("psc", 8'h01, {7'h0, powerOnClearData});
        chk("ev mask", 8'h00, eventEnableData);
        chk("sv mask", 8'h00, serviceEnableData);
        erq(8'h80);
        ctl.send(16'h0200);
        ctl.send(16'h0420);
        nrst = 0;
        repeat (3) @(posedge clk);
        #1 nrst = 1;
        repeat (3) @(posedge clk);
        #1 chk("sv mask", 8'h20, serviceEnableData);
        erq(8'h80);
        $display("test power cycle done");
        close_out();
    end
endmodule
